/* File: rtl/scsel_defines.svh */
// Purpose: offsets, field positions, reset values, clock rates and settling time of the clock selector
// Assumes: 125 MHz reference clock, Avalon-MM byte addresses
// Notes: definitions only
`ifndef SCSEL_DEFINES_SVH
`define SCSEL_DEFINES_SVH

`define SCSEL_REF_HZ 64'd125000000
`define SCSEL_FAST_2M_HZ 64'd2000000
`define SCSEL_FAST_4M_HZ 64'd4000000
`define SCSEL_FAST_8M_HZ 64'd8000000
`define SCSEL_SLOW_HZ 64'd32000

`define SCSEL_OFS_SYSCTL 4'h0
`define SCSEL_OFS_FASTCTL 4'h4
`define SCSEL_OFS_STATUS 4'h8

`define SCSEL_SYSCTL_SEL_HI 7
`define SCSEL_SYSCTL_SEL_LO 5
`define SCSEL_SYSCTL_FAST_IDLE 1
`define SCSEL_SYSCTL_SLOW_IDLE 0
`define SCSEL_SYSCTL_RESET 8'h00

`define SCSEL_FASTCTL_FREQ_HI 3
`define SCSEL_FASTCTL_FREQ_LO 2
`define SCSEL_FASTCTL_STABLE 1
`define SCSEL_FASTCTL_ENABLE 0
`define SCSEL_FASTCTL_RESET 8'h01

`define SCSEL_SEL_FAST 3'h0
`define SCSEL_SEL_SUB 3'h7

`define SCSEL_FAST_SETTLE_NS 16000

`endif

/* File: rtl/scsel_pkg.sv */
// Purpose: types shared by the clock selector files
// Assumes: nothing
// Notes: numbers live in scsel_defines.svh
package scsel_pkg;
    typedef enum logic [1:0] {FREQ_2M_A, FREQ_4M, FREQ_8M, FREQ_2M_B} scsel_freq_t;
    typedef enum {SW_IDLE, SW_WAIT_OLD, SW_WAIT_NEW} scsel_sw_state_t;
endpackage

/* File: rtl/scsel_nco.sv */
// Purpose: phase accumulator that stands in for an RC oscillator as a tick stream
// Assumes: inc below half of full scale
// Notes: tick is one REF_CLK cycle wide, one per oscillator period
`timescale 1ns/100ps
`default_nettype none
module scsel_nco #(
    parameter int ACC_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [ACC_W-1:0] inc,
    output logic tick_q
);
    logic [ACC_W:0] sum;
    logic [ACC_W-1:0] acc_q;

    assign sum = {1'b0, acc_q} + {1'b0, inc};

    // stopped oscillator restarts from phase zero so its first period is whole
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end
        else if (!run)
        begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            acc_q <= sum[ACC_W-1:0];
            tick_q <= sum[ACC_W];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/scsel_top.sv */
// Purpose: system clock generation and selection, clocks given as enable pulses on REF_CLK
// Assumes: Avalon-MM slave, byte addresses, only byte lane 0 carries register bits
// Notes: every clock output is a one-cycle pulse per period of that clock
//
// Overview of operation
// - The fast RC oscillator runs at 2, 4 or 8 MHz as chosen by software.
// - The slow RC oscillator runs at a nominal 32 kHz with nothing outside the block.
// - The three-bit source select chooses the system clock and may be changed at run time.
// - The select also offers the fast clock divided by 2 up to 64.
// - The subclock used as slow system clock comes from the slow RC oscillator.
// - The slow oscillator also feeds the watchdog; the time base takes the fast clock while it is stable, else the slow one.
// - With the system clock on the subclock, clearing the fast enable stops the fast oscillator.
// - While the fast oscillator is stopped no fast clock or divided fast clock is given out.
// - Oscillators are configured only by register writes, with no pin path.
// - Select code 0 is the fast clock, 1 to 6 divide by 2 to 64, and 7 picks the subclock.
// - Frequency code 00 is 2 MHz, 01 is 4 MHz, 10 is 8 MHz and 11 is 2 MHz.
// - Enabling or retuning the fast oscillator clears the stable flag until settled, and the new rate waits.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "scsel_defines.svh"
module scsel_top (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic SYSCLK_EN,
    output logic FAST_CLK_EN,
    output logic [5:0] FAST_DIV_EN,
    output logic SUB_CLK_EN,
    output logic WDT_CLK_EN,
    output logic TBASE_CLK_EN,
    output logic FAST_IDLE_EN,
    output logic SLOW_IDLE_EN
);
    localparam int SETTLE_CYC = (`SCSEL_FAST_SETTLE_NS * 125 + 999) / 1000;
    localparam logic [31:0] INC_2M = 32'((`SCSEL_FAST_2M_HZ << 32) / `SCSEL_REF_HZ);
    localparam logic [31:0] INC_4M = 32'((`SCSEL_FAST_4M_HZ << 32) / `SCSEL_REF_HZ);
    localparam logic [31:0] INC_8M = 32'((`SCSEL_FAST_8M_HZ << 32) / `SCSEL_REF_HZ);
    localparam logic [31:0] INC_SLOW = 32'((`SCSEL_SLOW_HZ << 32) / `SCSEL_REF_HZ);

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    logic wait_q;
    logic [31:0] rdata_q;
    logic [7:0] sysctl_q;
    logic [7:0] fastctl_q;
    logic [2:0] sel_req_q;
    logic fast_en_q;
    logic [1:0] freq_req_q;
    logic stable_q;
    logic [2:0] sel_act_q;
    scsel_pkg::scsel_sw_state_t sw_q;

    wire req = AVS_READ | AVS_WRITE;
    wire take = req & ~wait_q;
    wire hit_sys = AVS_ADDRESS == `SCSEL_OFS_SYSCTL;
    wire hit_fast = AVS_ADDRESS == `SCSEL_OFS_FASTCTL;
    wire hit_stat = AVS_ADDRESS == `SCSEL_OFS_STATUS;
    wire wr_lane = take & AVS_WRITE & AVS_BYTEENABLE[0];
    wire wr_sys = wr_lane & hit_sys;
    wire wr_fast = wr_lane & hit_fast;
    wire [7:0] wdat = AVS_WRITEDATA[7:0];
    wire [1:0] wr_freq = wdat[`SCSEL_FASTCTL_FREQ_HI:`SCSEL_FASTCTL_FREQ_LO];
    wire wr_en = wdat[`SCSEL_FASTCTL_ENABLE];
    wire [7:0] fast_rd = {4'h0, freq_req_q, stable_q, fast_en_q};
    wire [7:0] stat_rd = {sel_act_q, 3'h0, sw_q != scsel_pkg::SW_IDLE, stable_q};
    wire [7:0] rd_mux = hit_sys ? sysctl_q : hit_fast ? fast_rd : hit_stat ? stat_rd : 8'h00;

    // one wait cycle per access keeps the read mux off the bus output path
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q)
                rdata_q <= {24'h000000, rd_mux};
        end
    end

    // configuration reaches the block only through these writes
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sysctl_q <= `SCSEL_SYSCTL_RESET;
            fastctl_q <= `SCSEL_FASTCTL_RESET;
        end
        else
        begin
            if (wr_sys)
                sysctl_q <= {wdat[7:5], 3'h0, wdat[1:0]};
            if (wr_fast)
                fastctl_q <= {4'h0, wr_freq, 1'b0, wr_en};
        end
    end

    assign sel_req_q = sysctl_q[`SCSEL_SYSCTL_SEL_HI:`SCSEL_SYSCTL_SEL_LO];
    assign fast_en_q = fastctl_q[`SCSEL_FASTCTL_ENABLE];
    assign freq_req_q = fastctl_q[`SCSEL_FASTCTL_FREQ_HI:`SCSEL_FASTCTL_FREQ_LO];

    ////////////////////////////////////////////////////////////////////////////
    // fast oscillator: enable, settle and frequency hand-over
    logic [1:0] freq_act_q;
    logic [15:0] settle_q;
    logic fast_on_q;
    logic [2:0] sel_tgt_q;

    // kept running while it drives or is about to drive the system clock
    wire fast_on_d = fast_en_q | (sel_act_q != `SCSEL_SEL_SUB) | (sel_req_q != `SCSEL_SEL_SUB);
    wire retune = fast_on_q & wr_fast & (wr_freq != freq_req_q);
    wire restart = (fast_on_d & ~fast_on_q) | retune;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fast_on_q <= 1'b0;
            stable_q <= 1'b0;
            settle_q <= 16'h0000;
            freq_act_q <= 2'h0;
        end
        else
        begin
            fast_on_q <= fast_on_d;
            if (!fast_on_d)
            begin
                stable_q <= 1'b0;
                settle_q <= 16'h0000;
            end
            else if (restart)
            begin
                stable_q <= 1'b0;
                settle_q <= 16'(SETTLE_CYC);
            end
            else if (settle_q == 16'h0001)
            begin
                stable_q <= 1'b1;
                settle_q <= 16'h0000;
                freq_act_q <= freq_req_q;
            end
            else if (settle_q != 16'h0000)
                settle_q <= settle_q - 16'h0001;
        end
    end

    logic [31:0] fast_inc;
    always_comb
    begin
        case (scsel_pkg::scsel_freq_t'(freq_act_q))
            scsel_pkg::FREQ_4M: fast_inc = INC_4M;
            scsel_pkg::FREQ_8M: fast_inc = INC_8M;
            default: fast_inc = INC_2M;
        endcase
    end

    logic fast_tick;
    logic slow_tick;
    // ticks only flow once settled, so an unstable or stopped oscillator gives nothing
    scsel_nco #(.ACC_W(32)) u_fast_rc_oscillator (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .run(stable_q),
        .inc(fast_inc),
        .tick_q(fast_tick)
    );
    scsel_nco #(.ACC_W(32)) u_slow_rc_oscillator (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .run(1'b1),
        .inc(INC_SLOW),
        .tick_q(slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // fast clock divider chain
    logic [5:0] div_cnt_q;
    logic [5:0] div_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_div
            assign div_hit[gi] = fast_tick & (&div_cnt_q[gi:0]);
        end
    endgenerate

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            div_cnt_q <= 6'h00;
        else if (!stable_q)
            div_cnt_q <= 6'h00;
        else if (fast_tick)
            div_cnt_q <= div_cnt_q + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // source selection and glitch-free changeover
    function automatic logic src_tick(input logic [2:0] s, input logic f, input logic [5:0] d, input logic sub);
        logic r;
        r = 1'b0;
        if (s == `SCSEL_SEL_SUB)
            r = sub;
        else if (s == `SCSEL_SEL_FAST)
            r = f;
        else
            r = d[s - 3'h1];
        return r;
    endfunction

    wire act_tick = src_tick(sel_act_q, fast_tick, div_hit, slow_tick);
    wire tgt_tick = src_tick(sel_tgt_q, fast_tick, div_hit, slow_tick);
    // the new source's first edge only marks phase; the period after it is whole
    wire sys_pulse = act_tick & (sw_q != scsel_pkg::SW_WAIT_NEW);

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sw_q <= scsel_pkg::SW_IDLE;
            sel_act_q <= `SCSEL_SEL_FAST;
            sel_tgt_q <= `SCSEL_SEL_FAST;
        end
        else
        begin
            case (sw_q)
                scsel_pkg::SW_IDLE:
                    if (sel_req_q != sel_act_q)
                        sw_q <= scsel_pkg::SW_WAIT_OLD;
                scsel_pkg::SW_WAIT_OLD:
                    if (act_tick)
                    begin
                        sel_act_q <= sel_req_q;
                        sel_tgt_q <= sel_req_q;
                        sw_q <= scsel_pkg::SW_WAIT_NEW;
                    end
                default:
                    if (tgt_tick)
                        sw_q <= scsel_pkg::SW_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered clock outputs
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SYSCLK_EN <= 1'b0;
            FAST_CLK_EN <= 1'b0;
            FAST_DIV_EN <= 6'h00;
            SUB_CLK_EN <= 1'b0;
            WDT_CLK_EN <= 1'b0;
            TBASE_CLK_EN <= 1'b0;
        end
        else
        begin
            SYSCLK_EN <= sys_pulse;
            FAST_CLK_EN <= fast_tick;
            FAST_DIV_EN <= div_hit;
            SUB_CLK_EN <= slow_tick;
            WDT_CLK_EN <= slow_tick;
            TBASE_CLK_EN <= stable_q ? fast_tick : slow_tick;
        end
    end

    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;
    assign FAST_IDLE_EN = sysctl_q[`SCSEL_SYSCTL_FAST_IDLE];
    assign SLOW_IDLE_EN = sysctl_q[`SCSEL_SYSCTL_SLOW_IDLE];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence seq_bus_ack;
        !wait_q ##1 wait_q;
    endsequence
    sequence seq_two_dead;
        !stable_q ##1 !stable_q;
    endsequence

    chk_bus_ack_once: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        req && wait_q |=> seq_bus_ack)
        else $error("bus answer not one cycle after request");
    chk_fast_dead: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        seq_two_dead |=> !FAST_CLK_EN && FAST_DIV_EN == 6'h00)
        else $error("fast clock given out while oscillator stopped");
    chk_fast_stop: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !fast_en_q && sel_act_q == `SCSEL_SEL_SUB && sel_req_q == `SCSEL_SEL_SUB |=> !stable_q)
        else $error("fast oscillator still running after disable on subclock");
    chk_retune_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        retune |=> !stable_q ##1 !stable_q)
        else $error("stable flag not cleared on retune");
    chk_freq_held: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        settle_q > 16'h0001 |=> $stable(freq_act_q))
        else $error("new frequency applied before settling");
    chk_freq_code: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        freq_act_q == 2'h3 |-> fast_inc == INC_2M)
        else $error("code 11 not mapped to 2 MHz");
    chk_sel_follow: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        sw_q == scsel_pkg::SW_IDLE && sel_act_q == 3'h6 && div_hit[5] |=> SYSCLK_EN)
        else $error("divide by 64 tick not passed to system clock");
    chk_sub_follow: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        sw_q == scsel_pkg::SW_IDLE && sel_act_q == `SCSEL_SEL_SUB && slow_tick |=> SYSCLK_EN)
        else $error("subclock tick not passed to system clock");
    chk_no_short: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        sw_q == scsel_pkg::SW_WAIT_NEW |=> !SYSCLK_EN)
        else $error("system clock pulse during changeover");
    chk_wdt_feed: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        slow_tick |=> WDT_CLK_EN && SUB_CLK_EN)
        else $error("watchdog clock missing");
    chk_div_rate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        fast_tick && div_cnt_q == 6'h3F |=> FAST_DIV_EN == 6'h3F)
        else $error("divided ticks not aligned");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the system clock selector
// Assumes: 125 MHz REF_CLK, Avalon-MM slave with one wait cycle
// Notes: rates are counted in REF_CLK cycles, so small tolerances are allowed
`timescale 1ns/100ps
`default_nettype none
module tb_top;
logic REF_CLK = 1'b0;
logic RST_N = 1'b0;
logic [3:0] AVS_ADDRESS = 4'h0;
logic AVS_READ = 1'b0;
logic AVS_WRITE = 1'b0;
logic [31:0] AVS_WRITEDATA = 32'h0;
logic [3:0] AVS_BYTEENABLE = 4'h0;
logic [31:0] AVS_READDATA;
logic AVS_WAITREQUEST, SYSCLK_EN, FAST_CLK_EN, SUB_CLK_EN, WDT_CLK_EN, TBASE_CLK_EN, FAST_IDLE_EN, SLOW_IDLE_EN;
logic [5:0] FAST_DIV_EN;
int mismatches = 0;
int checks_done = 0;
int cyc = 0;
int gap = 0;
bit gap_on = 1'b0;
int n_sys, n_fast, n_sub, n_wdt, n_tb, wcyc;
int n_div[6];
logic [31:0] seed = 32'h36;
logic [31:0] exp_q[$];

always #4 REF_CLK = ~REF_CLK;

scsel_top scsel_top_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SYSCLK_EN(SYSCLK_EN),
    .FAST_CLK_EN(FAST_CLK_EN), .FAST_DIV_EN(FAST_DIV_EN), .SUB_CLK_EN(SUB_CLK_EN), .WDT_CLK_EN(WDT_CLK_EN),
    .TBASE_CLK_EN(TBASE_CLK_EN), .FAST_IDLE_EN(FAST_IDLE_EN), .SLOW_IDLE_EN(SLOW_IDLE_EN));

////////////////////////////////////////////////////////////////////////
task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

task check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask

// bench-side counts only, never design values
task check_range(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi)
    begin
        mismatches++;
        $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
endtask

function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction

////////////////////////////////////////////////////////////////////////
task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    do
    begin
        @(posedge REF_CLK);
        n++;
    end
    while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (n >= 20)
        check_range("bus_answer", 0, 19, n);
endtask

task wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = xs();
    bus(1'b1, a, {r[31:8], d}, r[3:0] | 4'h1);
endtask

task rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, a, xs(), 4'hF);
endtask

// counts pulses until nf fast ticks or mx cycles have passed
task window(input int nf, input int mx);
    n_sys = 0;
    n_fast = 0;
    n_sub = 0;
    n_wdt = 0;
    n_tb = 0;
    wcyc = 0;
    foreach (n_div[k]) n_div[k] = 0;
    while (n_fast < nf && wcyc < mx)
    begin
        @(posedge REF_CLK);
        wcyc++;
        n_sys += int'(SYSCLK_EN === 1'b1);
        n_fast += int'(FAST_CLK_EN === 1'b1);
        n_sub += int'(SUB_CLK_EN === 1'b1);
        n_wdt += int'(WDT_CLK_EN === 1'b1);
        n_tb += int'(TBASE_CLK_EN === 1'b1);
        foreach (n_div[k]) n_div[k] += int'(FAST_DIV_EN[k] === 1'b1);
    end
endtask

task wait_fast;
    int n;
    n = 0;
    while (FAST_CLK_EN !== 1'b1 && n < 4000)
    begin
        @(posedge REF_CLK);
        n++;
    end
    check_range("fast_start", 0, 3999, n);
endtask

////////////////////////////////////////////////////////////////////////
// read answers are compared here, in order of issue
always @(posedge REF_CLK)
begin
    cyc++;
    if (cyc > 95000)
    begin
        mismatches++;
        test_done;
    end
    else
    begin
        if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0)
            check_reg("readdata", exp_q.pop_front(), AVS_READDATA);
        gap++;
        if (SYSCLK_EN === 1'b1)
        begin
            // shortest whole period around the switch is one subclock period
            if (gap_on)
                check_range("sysclk_gap", 3900, 12500, gap);
            gap = 0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
initial
begin
    logic [31:0] r;
    int per[4];
    per = '{1000, 500, 250, 1000};
    repeat (5) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h01);
    rd(4'h8, 8'h00);
    window(1, 1000);
    check_range("fast_unstable", 0, 0, n_fast);
    wait_fast;
    rd(4'h4, 8'h03);
    rd(4'h8, 8'h01);
    for (int f = 0; f < 4; f++)
    begin
        wr(4'h4, {4'h0, f[1:0], 2'b01});
        if (f > 0)
        begin
            rd(4'h4, {4'h0, f[1:0], 2'b01});
            window(1, 1000);
            check_range("retune_quiet", 0, 0, n_fast);
            wait_fast;
        end
        // start on a fast tick so the measured window spans whole periods
        window(1, 3000);
        window(16, 3000);
        check_range("fast_period", per[f] - 3, per[f] + 3, wcyc);
        check_range("tbase_fast", 15, 17, n_tb);
        if (f == 2)
        begin
            for (int s = 0; s < 7; s++)
            begin
                r = xs();
                wr(4'h0, {s[2:0], 3'b000, r[1:0]});
                window(200, 8000);
                window(128, 8000);
                check_range("sysclk_count", (128 >> s) - 1, (128 >> s) + 1, n_sys);
                check_reg("idle_bits", {30'h0, r[1:0]}, {30'h0, FAST_IDLE_EN, SLOW_IDLE_EN});
                rd(4'h0, {s[2:0], 3'b000, r[1:0]});
                rd(4'h8, {s[2:0], 5'h01});
                if (s == 0)
                    foreach (n_div[k]) check_range("div_count", (64 >> k) - 1, (64 >> k) + 1, n_div[k]);
            end
        end
    end
    // slow fast clock at /64 into subclock: gaps stay whole periods
    gap_on = 1'b1;
    wr(4'h0, 8'hE0);
    window(99999, 12500);
    rd(4'h8, 8'hE1);
    gap_on = 1'b0;
    wr(4'h4, 8'h0C);
    // a tick already in flight when the stop lands still comes out
    repeat (3) @(posedge REF_CLK);
    window(99999, 8000);
    check_range("fast_stopped", 0, 0, n_fast + n_div[0] + n_div[5]);
    check_range("sub_sysclk", 1, 3, n_sys);
    check_range("sub_rate", 1, 3, n_sub);
    check_range("wdt_rate", n_sub, n_sub, n_wdt);
    check_range("tbase_slow", 1, 3, n_tb);
    bus(1'b1, 4'h0, 32'h000000FF, 4'hE);
    rd(4'h0, 8'hE0);
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'h00);
    wr(4'h4, 8'h09);
    wait_fast;
    wr(4'h0, 8'h00);
    window(99999, 8000);
    window(64, 3000);
    check_range("back_to_fast", 63, 65, n_sys);
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h01);
    test_done;
end
endmodule
`default_nettype wire
